// *** src/host_bus_ctrl.sv ***
// Host-side controller driving the device's multiplexed or plain address/data pins
//
// Added by the designer: the register offsets and the strobed register port.
module host_bus_ctrl (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [31:0]      reg_rdata,
  input  wire logic [7:0]  low_addr_data_pins_in,
  output logic [7:0]       low_addr_data_pins_out,
  output logic [7:0]       low_addr_data_pins_oe,
  input  wire logic [7:0]  high_addr_data_pins_in,
  output logic [7:0]       high_addr_data_pins_out,
  output logic [7:0]       high_addr_data_pins_oe,
  input  wire logic [7:0]  port_a_in,
  output logic [7:0]       port_a_out,
  output logic [7:0]       port_a_oe,
  input  wire logic [7:0]  port_b_pins_in,
  output logic [7:0]       port_b_pins_out,
  output logic [7:0]       port_b_pins_oe,
  output logic [2:0]       extended_address_bits,
  output logic             upper_addr_or_select_in,
  output logic             address_latch_strobe,
  output logic             write_strobe_b,
  output logic             read_strobe_b
);
  import host_bus_pkg::*;

  // ---------------------------------------------------------------
  // Reset release and input synchronisers
  // ---------------------------------------------------------------
  logic        rst_m_q;
  logic        rst_q_b;
  logic [23:0] pin_m_q;
  logic [23:0] pin_s_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_q <= 1'b0;
      rst_q_b <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_q_b <= rst_m_q;
    end
  end

  always_ff @(posedge clock or negedge rst_q_b) begin
    if (!rst_q_b) begin
      pin_m_q <= 24'h000000;
      pin_s_q <= 24'h000000;
    end else begin
      pin_m_q <= {port_b_pins_in, high_addr_data_pins_in, low_addr_data_pins_in ^ 8'h00};
      pin_s_q <= pin_m_q;
    end
  end

  logic [7:0] porta_m_q;
  logic [7:0] porta_s_q;
  always_ff @(posedge clock or negedge rst_q_b) begin
    if (!rst_q_b) begin
      porta_m_q <= 8'h00;
      porta_s_q <= 8'h00;
    end else begin
      porta_m_q <= port_a_in;
      porta_s_q <= porta_m_q;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [2:0]  ctrl_q;
  logic [19:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic [15:0] rd_word;
  logic        done_q;
  logic        rnw_q;
  cyc_state_t  state_q;
  cyc_state_t  state_d;

  wire       busy      = (state_q != ST_IDLE);
  wire       sel_ctrl  = reg_write && (reg_addr == REG_CTRL);
  wire       sel_addr  = reg_write && (reg_addr == REG_ADDR);
  wire       sel_wdata = reg_write && (reg_addr == REG_WDATA);
  wire       sel_cmd   = reg_write && (reg_addr == REG_CMD) && !busy;
  wire       start_wr  = sel_cmd && reg_wdata[CMD_WRITE];
  wire       start_rd  = sel_cmd && reg_wdata[CMD_READ] && !reg_wdata[CMD_WRITE];
  wire       start     = start_wr || start_rd;
  bus_mode_t mode;
  assign mode = bus_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
  wire       mux       = is_mux(mode);
  wire       wide      = is_wide(mode);
  wire       ale_pol   = ctrl_q[CTRL_ALE_POL];

  always_ff @(posedge clock or negedge rst_q_b) begin
    if (!rst_q_b) begin
      ctrl_q <= CTRL_RESET[2:0];
    end else if (sel_ctrl && !busy) begin
      ctrl_q <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge clock or negedge rst_q_b) begin
    if (!rst_q_b) begin
      addr_q  <= 20'h00000;
      wdata_q <= 16'h0000;
    end else begin
      if (sel_addr && !busy) addr_q <= reg_wdata[19:0];
      if (sel_wdata && !busy) wdata_q <= reg_wdata[15:0];
    end
  end

  // ---------------------------------------------------------------
  // Pin cycle sequencer
  // ---------------------------------------------------------------
  logic       tmr_load;
  logic [7:0] tmr_count;
  logic       tmr_exp;

  bus_timer u_timer (
    .clock   (clock),
    .rst_q_b (rst_q_b),
    .load    (tmr_load),
    .count   (tmr_count),
    .expired (tmr_exp)
  );

  always_comb begin
    state_d   = state_q;
    tmr_load  = 1'b0;
    tmr_count = 8'h00;
    case (state_q)
      ST_IDLE: begin
        if (start) begin
          tmr_load  = 1'b1;
          state_d   = mux ? ST_ALE : ST_SETUP;
          tmr_count = mux ? ALE_CYC : SETUP_CYC;
        end
      end
      ST_ALE: begin
        if (tmr_exp) begin
          tmr_load  = 1'b1;
          tmr_count = SETUP_CYC;
          state_d   = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (tmr_exp) begin
          tmr_load  = 1'b1;
          tmr_count = STROBE_CYC;
          state_d   = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (tmr_exp) begin
          tmr_load  = 1'b1;
          tmr_count = HOLD_CYC;
          state_d   = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (tmr_exp) state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  wire strobe_end = (state_q == ST_STROBE) && tmr_exp;

  always_ff @(posedge clock or negedge rst_q_b) begin
    if (!rst_q_b) begin
      state_q <= ST_IDLE;
      rnw_q   <= 1'b0;
      done_q  <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      if (start) rnw_q <= start_rd;
      if (strobe_end) done_q <= 1'b1;
      else if (start) done_q <= 1'b0;
      if (strobe_end && rnw_q) rdata_q <= rd_word;
    end
  end

  // ---------------------------------------------------------------
  // Pin drive per mode
  // ---------------------------------------------------------------
  // Pins are registered: look ahead so the address stands with the latch strobe,
  // and keep it one cycle past the strobe's trailing edge as hold time
  wire in_cycle  = busy || (state_d != ST_IDLE);
  wire addr_ph   = (state_q == ST_ALE) || (state_d == ST_ALE);
  wire data_ph   = (state_q == ST_SETUP) || (state_q == ST_STROBE) || (state_q == ST_HOLD);
  wire drive_dat = data_ph && !rnw_q;
  // Multiplexed reads low byte on AD pins, plain modes on port A
  assign rd_word[7:0]  = mux ? pin_s_q[7:0] : porta_s_q;
  // High byte on AD8-15 in mux-16, on port B in plain-16, else zero
  assign rd_word[15:8] = !wide ? 8'h00 : (mux ? pin_s_q[15:8] : pin_s_q[23:16]);

  always_ff @(posedge clock or negedge rst_q_b) begin
    if (!rst_q_b) begin
      low_addr_data_pins_out  <= 8'h00;
      low_addr_data_pins_oe   <= 8'h00;
      high_addr_data_pins_out <= 8'h00;
      high_addr_data_pins_oe  <= 8'h00;
      port_a_out              <= 8'h00;
      port_a_oe               <= 8'h00;
      port_b_pins_out         <= 8'h00;
      port_b_pins_oe          <= 8'h00;
      extended_address_bits   <= 3'h0;
      upper_addr_or_select_in <= 1'b0;
      address_latch_strobe    <= 1'b0;
      write_strobe_b          <= 1'b1;
      read_strobe_b           <= 1'b1;
    end else begin
      // Address on shared pins during latch phase, data or release after
      low_addr_data_pins_out <= (mux && !addr_ph) ? wdata_q[7:0] : addr_q[7:0];
      low_addr_data_pins_oe  <= (in_cycle && (!mux || addr_ph || drive_dat)) ? 8'hFF : 8'h00;
      // High pins shared only in mux-16
      high_addr_data_pins_out <= (mux && wide && !addr_ph) ? wdata_q[15:8] : addr_q[15:8];
      high_addr_data_pins_oe  <= (in_cycle && (!(mux && wide) || addr_ph || drive_dat)) ?
                                 8'hFF : 8'h00;
      // Port A carries low data in plain modes
      port_a_out <= wdata_q[7:0];
      port_a_oe  <= (!mux && drive_dat) ? 8'hFF : 8'h00;
      // Port B carries high data in plain-16; otherwise it is the device's port
      port_b_pins_out <= wdata_q[15:8];
      port_b_pins_oe  <= (!mux && wide && drive_dat) ? 8'hFF : 8'h00;
      extended_address_bits   <= addr_q[18:16];
      upper_addr_or_select_in <= addr_q[19];
      // Strobe pulse, trailing edge marks the latch point
      address_latch_strobe <= ale_pol ? (state_d == ST_ALE) : !(state_d == ST_ALE);
      write_strobe_b <= !((state_d == ST_STROBE) && !(start ? start_rd : rnw_q));
      read_strobe_b  <= !((state_d == ST_STROBE) && (start ? start_rd : rnw_q));
    end
  end

  // ---------------------------------------------------------------
  // Register read path
  // ---------------------------------------------------------------
  wire [31:0] rd_mux =
    (reg_addr == REG_CTRL)   ? {29'h0, ctrl_q} :
    (reg_addr == REG_ADDR)   ? {12'h0, addr_q} :
    (reg_addr == REG_WDATA)  ? {16'h0, wdata_q} :
    (reg_addr == REG_STATUS) ? {30'h0, done_q, busy} :
    (reg_addr == REG_RDATA)  ? {16'h0, rdata_q} : 32'h0000_0000;

  always_ff @(posedge clock or negedge rst_q_b) begin
    if (!rst_q_b) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_read ? rd_mux : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_mode_stable;
    @(posedge clock) disable iff (!rst_q_b) busy |=> $stable(ctrl_q);
  endproperty
  a_mode_stable: assert property (p_mode_stable) else $error("mode changed in cycle");

  property p_no_dual_strobe;
    @(posedge clock) disable iff (!rst_q_b) !(!read_strobe_b && !write_strobe_b);
  endproperty
  a_no_dual_strobe: assert property (p_no_dual_strobe) else $error("both strobes");

  property p_read_releases;
    @(posedge clock) disable iff (!rst_q_b)
      (!read_strobe_b && mux) |-> (low_addr_data_pins_oe == 8'h00);
  endproperty
  a_read_releases: assert property (p_read_releases) else $error("low pins driven on read");

  property p_plain_addr;
    @(posedge clock) disable iff (!rst_q_b)
      (!read_strobe_b && !mux) |-> (low_addr_data_pins_oe == 8'hFF);
  endproperty
  a_plain_addr: assert property (p_plain_addr) else $error("address not held");

  property p_high_addr_only;
    @(posedge clock) disable iff (!rst_q_b)
      (!write_strobe_b && !(mux && wide)) |-> (high_addr_data_pins_out == addr_q[15:8]);
  endproperty
  a_high_addr_only: assert property (p_high_addr_only) else $error("high pins not address");

  property p_portb_data;
    @(posedge clock) disable iff (!rst_q_b)
      (!write_strobe_b && !mux && wide) |-> (port_b_pins_oe == 8'hFF);
  endproperty
  a_portb_data: assert property (p_portb_data) else $error("port B not driven");

  property p_ale_addr;
    @(posedge clock) disable iff (!rst_q_b)
      (address_latch_strobe == ale_pol && busy) |-> (low_addr_data_pins_out == addr_q[7:0]);
  endproperty
  a_ale_addr: assert property (p_ale_addr) else $error("address absent at latch");

  property p_ext_addr;
    @(posedge clock) disable iff (!rst_q_b)
      !busy ##1 busy |-> ##1 (extended_address_bits == addr_q[18:16]);
  endproperty
  a_ext_addr: assert property (p_ext_addr) else $error("extended address wrong");

endmodule

// *** src/host_bus_pkg.sv ***
// Constants and types shared by the host bus controller design
package host_bus_pkg;

  // ---------------------------------------------------------------
  // Bus modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_MUX_8    = 2'b00,
    MODE_MUX_16   = 2'b01,
    MODE_NMUX_8   = 2'b10,
    MODE_NMUX_16  = 2'b11
  } bus_mode_t;

  // ---------------------------------------------------------------
  // Controller register map (word index on the command port)
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_ADDR    = 4'h1;
  localparam logic [3:0] REG_WDATA   = 4'h2;
  localparam logic [3:0] REG_CMD     = 4'h3;
  localparam logic [3:0] REG_STATUS  = 4'h4;
  localparam logic [3:0] REG_RDATA   = 4'h5;

  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_ALE_POL   = 2;
  localparam int CMD_WRITE      = 0;
  localparam int CMD_READ       = 1;
  localparam int STAT_BUSY      = 0;
  localparam int STAT_DONE      = 1;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Pin-cycle timing (ns, and clock cycles at 8 ns)
  // ---------------------------------------------------------------
  localparam int CLK_NS        = 8;
  localparam int ALE_NS        = 40;
  localparam int SETUP_NS      = 24;
  localparam int STROBE_NS     = 120;
  localparam int HOLD_NS       = 16;
  localparam logic [7:0] ALE_CYC    = 8'((ALE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] SETUP_CYC  = 8'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] STROBE_CYC = 8'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] HOLD_CYC   = 8'((HOLD_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ALE    = 3'b001,
    ST_SETUP  = 3'b010,
    ST_STROBE = 3'b011,
    ST_HOLD   = 3'b100
  } cyc_state_t;

  function automatic logic is_mux(input bus_mode_t m);
    return (m == MODE_MUX_8) || (m == MODE_MUX_16);
  endfunction

  function automatic logic is_wide(input bus_mode_t m);
    return (m == MODE_MUX_16) || (m == MODE_NMUX_16);
  endfunction

endpackage

// *** src/bus_timer.sv ***
// Cycle counter for the pin-phase durations
module bus_timer (
  input  wire logic       clock,
  input  wire logic       rst_q_b,
  input  wire logic       load,
  input  wire logic [7:0] count,
  output logic            expired
);

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;

  assign cnt_d   = load ? count : (cnt_q != 8'h00 ? cnt_q - 8'h01 : 8'h00);
  // Depends on the count only: load is itself decoded from expired by the sequencer
  assign expired = (cnt_q == 8'h01);

  always_ff @(posedge clock or negedge rst_q_b) begin
    if (!rst_q_b) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// *** test/dev_bus_model.sv ***
// Behavioural model of the peripheral's host bus pins and its memory
module dev_bus_model (
  input  wire logic                    rst_b,
  input  wire host_bus_pkg::bus_mode_t mode,
  input  wire logic                    ale_pol,
  input  wire logic [7:0]              lo_out,
  input  wire logic [7:0]              lo_oe,
  input  wire logic [7:0]              hi_out,
  input  wire logic [7:0]              hi_oe,
  input  wire logic [7:0]              pa_out,
  input  wire logic [7:0]              pa_oe,
  input  wire logic [7:0]              pb_out,
  input  wire logic [7:0]              pb_oe,
  input  wire logic [2:0]              ext,
  input  wire logic                    upper,
  input  wire logic                    ale,
  input  wire logic                    wr_b,
  input  wire logic                    rd_b,
  output logic [7:0]                   lo_in,
  output logic [7:0]                   hi_in,
  output logic [7:0]                   pa_in,
  output logic [7:0]                   pb_in,
  output logic [19:0]                  last_addr
);
  import host_bus_pkg::*;
  localparam logic [7:0] PB_DIR = 8'h01;
  logic        mux_w;
  logic        wide_w;
  logic        rd_on_w;
  logic [15:0] lat_q;
  logic [15:0] addr_w;
  logic [15:0] rdat_w;
  logic [15:0] wdat_w;
  logic [2:0]  ext_lat_q;
  logic [2:0]  ext_w;
  logic [7:0]  idx_w;
  logic [7:0]  cs_b_w;
  logic [15:0] mem [256];

  // Undriven lines show the inverse of the host's last value
  function automatic logic [7:0] res(input logic [7:0] ho, he, dv, de);
    return (he & ho) | (~he & de & dv) | (~he & ~de & ~ho);
  endfunction

  assign mux_w   = (mode == MODE_MUX_8) || (mode == MODE_MUX_16);
  assign wide_w  = (mode == MODE_MUX_16) || (mode == MODE_NMUX_16);
  assign rd_on_w = rst_b && !rd_b;
  always_latch begin
    if (mux_w && ale == ale_pol) begin
      lat_q     <= {hi_in, lo_in};
      ext_lat_q <= ext;
    end
  end
  assign ext_w  = mux_w ? ext_lat_q : ext;
  assign addr_w = !mux_w ? {hi_in, lo_in} : {wide_w ? lat_q[15:8] : hi_in, lat_q[7:0]};
  assign idx_w  = {upper, ext_w, addr_w[15], addr_w[8], addr_w[7], addr_w[0]};
  assign rdat_w = mem[idx_w];
  assign wdat_w = mux_w ? {wide_w ? hi_in : 8'h00, lo_in} : {wide_w ? pb_in : 8'h00, pa_in};
  assign cs_b_w = {7'h7F, !(rst_b && !(rd_b && wr_b))};
  assign lo_in  = res(lo_out, lo_oe, rdat_w[7:0], {8{mux_w && rd_on_w}});
  assign hi_in  = res(hi_out, hi_oe, rdat_w[15:8], {8{mux_w && wide_w && rd_on_w}});
  assign pa_in  = res(pa_out, pa_oe, rdat_w[7:0], {8{!mux_w && rd_on_w}});
  assign pb_in  = (!mux_w && wide_w) ? res(pb_out, pb_oe, rdat_w[15:8], {8{rd_on_w}})
                                     : res(pb_out, pb_oe, cs_b_w, PB_DIR);
  always @(posedge wr_b) if (rst_b) mem[idx_w] <= wdat_w;
  always @(negedge rd_b or negedge wr_b) last_addr <= {upper, ext_w, addr_w};
endmodule

// *** test/host_bus_ctrl_tb_top.sv ***
// Self-checking bench for the host bus controller against the peripheral model
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("BAD %s exp %0h got %0h", nm, exp, got); end end
module host_bus_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import host_bus_pkg::*;
  logic        clock, rst_b, reg_write, reg_read, pol, upper, ale, wr_b, rd_b, s_ale;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [7:0]  lo_out, lo_oe, lo_in, hi_out, hi_oe, hi_in, pa_out, pa_oe, pa_in;
  logic [7:0]  pb_out, pb_oe, pb_in, s_lo, s_hi, s_pa, s_pb;
  logic [2:0]  ext;
  logic [19:0] last_addr;
  bus_mode_t   mode;
  int          bad_count, check_count;

  host_bus_ctrl host_bus_ctrl_i (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .low_addr_data_pins_in(lo_in), .low_addr_data_pins_out(lo_out), .low_addr_data_pins_oe(lo_oe),
    .high_addr_data_pins_in(hi_in), .high_addr_data_pins_out(hi_out),
    .high_addr_data_pins_oe(hi_oe), .port_a_in(pa_in), .port_a_out(pa_out), .port_a_oe(pa_oe),
    .port_b_pins_in(pb_in), .port_b_pins_out(pb_out), .port_b_pins_oe(pb_oe),
    .extended_address_bits(ext), .upper_addr_or_select_in(upper), .address_latch_strobe(ale),
    .write_strobe_b(wr_b), .read_strobe_b(rd_b));

  dev_bus_model dev_bus_model_i (.rst_b(rst_b), .mode(mode), .ale_pol(pol), .lo_out(lo_out),
    .lo_oe(lo_oe), .hi_out(hi_out), .hi_oe(hi_oe), .pa_out(pa_out), .pa_oe(pa_oe),
    .pb_out(pb_out), .pb_oe(pb_oe), .ext(ext), .upper(upper), .ale(ale), .wr_b(wr_b),
    .rd_b(rd_b), .lo_in(lo_in), .hi_in(hi_in), .pa_in(pa_in), .pb_in(pb_in),
    .last_addr(last_addr));

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic give_up();
    $display("BAD wait exp end got timeout");
    bad_count++;
    results();
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Start a pin cycle, note the drivers once a strobe falls, then poll until idle
  task automatic run(input logic [31:0] cmd);
    logic [31:0] st;
    int          n;
    reg_wr(REG_CMD, cmd);
    n = 0;
    while (rd_b === 1'b1 && wr_b === 1'b1 && n < 100) begin
      @(posedge clock);
      #1 n++;
    end
    if (n == 100) give_up();
    s_lo  = lo_oe;
    s_hi  = hi_oe;
    s_pa  = pa_oe;
    s_pb  = pb_oe;
    s_ale = ale;
    n = 0;
    do begin
      reg_rd(REG_STATUS, st);
      n++;
    end while (st[STAT_BUSY] !== 1'b0 && n < 100);
    if (n == 100) give_up();
    `CHK("done", 1'b1, st[STAT_DONE])
  endtask

  task automatic setup(input bus_mode_t m, input logic p);
    mode = m;
    pol  = p;
    reg_wr(REG_CTRL, {29'h0, p, m});
  endtask

  task automatic wr_cyc(input logic [19:0] a, input logic [15:0] d, input logic [31:0] cmd);
    reg_wr(REG_ADDR, {12'h0, a});
    reg_wr(REG_WDATA, {16'h0, d});
    run(cmd);
    `CHK("wr addr", a, last_addr)
  endtask

  task automatic rd_cyc(input logic [19:0] a, input logic [15:0] exp);
    logic [31:0] rd;
    reg_wr(REG_ADDR, {12'h0, a});
    run(32'h2);
    `CHK("rd addr", a, last_addr)
    reg_rd(REG_RDATA, rd);
    `CHK("rdata", {16'h0, exp}, rd)
  endtask

  task automatic sc_reset();
    logic [31:0] rd;
    repeat (5) @(posedge clock);
    #1;
    `CHK("reset oe", 32'h0, {lo_oe, hi_oe, pa_oe, pb_oe})
    `CHK("reset strobes", 3'b011, {ale, wr_b, rd_b})
    @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    reg_rd(REG_CTRL, rd);
    `CHK("ctrl reset", CTRL_RESET, rd)
    reg_rd(REG_STATUS, rd);
    `CHK("status reset", 32'h0, rd)
    reg_rd(4'hF, rd);
    `CHK("unmapped", 32'h0, rd)
  endtask

  task automatic sc_modes();
    logic [19:0] a;
    logic [15:0] d;
    for (int i = 0; i < 4; i++) begin
      a = 20'h12345 + 20'(i) * 20'h11111;
      d = 16'hA5C3 ^ (16'(i) * 16'h1111);
      setup(bus_mode_t'(i), i[0]);
      wr_cyc(a, d, 32'h1);
      `CHK("wr lo oe", 8'hFF, s_lo)
      `CHK("wr hi oe", 8'hFF, s_hi)
      `CHK("wr pa oe", i[1] ? 8'hFF : 8'h00, s_pa)
      `CHK("wr pb oe", i == 3 ? 8'hFF : 8'h00, s_pb)
      `CHK("wr ale", !i[0], s_ale)
      rd_cyc(a, i[0] ? d : {8'h00, d[7:0]});
      `CHK("rd lo oe", i[1] ? 8'hFF : 8'h00, s_lo)
      `CHK("rd hi oe", i == 1 ? 8'h00 : 8'hFF, s_hi)
      `CHK("rd pa oe", 8'h00, s_pa)
      `CHK("rd pb oe", 8'h00, s_pb)
    end
  endtask

  task automatic sc_ext();
    setup(MODE_MUX_8, 1'b1);
    wr_cyc(20'h50081, 16'h0011, 32'h1);
    wr_cyc(20'hA0081, 16'h0022, 32'h1);
    rd_cyc(20'h50081, 16'h0011);
    rd_cyc(20'hA0081, 16'h0022);
  endtask

  // Orders sent while busy must not disturb the cycle in flight
  task automatic sc_busy();
    logic [31:0] st;
    setup(MODE_MUX_16, 1'b0);
    reg_wr(REG_ADDR, 32'h3C3C3);
    reg_wr(REG_WDATA, 32'h7E81);
    reg_wr(REG_CMD, 32'h3);
    reg_wr(REG_ADDR, 32'h00000);
    reg_wr(REG_CTRL, 32'h2);
    reg_rd(REG_STATUS, st);
    `CHK("busy", 1'b1, st[STAT_BUSY])
    run(32'h0);
    `CHK("busy addr", 20'h3C3C3, last_addr)
    rd_cyc(20'h3C3C3, 16'h7E81);
  endtask

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  initial begin
    rst_b       = 1'b0;
    reg_addr    = 4'h0;
    reg_wdata   = 32'h0;
    reg_write   = 1'b0;
    reg_read    = 1'b0;
    mode        = MODE_MUX_8;
    pol         = 1'b0;
    bad_count   = 0;
    check_count = 0;
    sc_reset();
    sc_modes();
    sc_ext();
    sc_busy();
    results();
  end
endmodule
